// ==== rcs_top.sv ====
// Reference clock output select: registers, loss behaviour and output pin control
// Operation
// - Free-run bit acts only when the source goes through the synthesizer.
// - Free-run clear: output locks to source at the programmed frequency code.
// - Free-run set: output free-runs from master clock at programmed frequency.
// - On source loss, free-run, bypass and holdover bits together set the output.
// - External clock lost: high, or free-run if synthesizer used and free-run set.
// - Channel lost, synthesizer used: free-run unless holdover set with free-run clear.
// - Channel lost, bypassed: fixed T1/E1 free-run clock, or high with holdover.
// - Frequency code is ignored while the synthesizer is bypassed.
// - Code 000 gives source rate when locked; undefined in free-run; 011 reserved.
// - Codes 001..111 map to 8k, 64k, 4.096M, 8.192M, 19.44M, 32.768M.
// - Bit 6 enables the output pin driver; default driven.
// - Bit 5 declares the external clock rate: 0 T1 default, 1 E1.
// - Codes 0..21 pick a recovered channel, default 1; 22..31 external.
`timescale 1ns/1ps
`include "rcs_cfg.svh"

module rcs_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // AHB-Lite slave
    input rcs_pkg::rcs_ahb_req_t ahb_req,
    output rcs_pkg::rcs_ahb_rsp_t ahb_rsp,
    // Candidate source clocks
    input wire logic [`RCS_NUM_CH-1:0] recovered_channel_clock,
    input wire logic [`RCS_NUM_CH-1:0] channel_clock_lost,
    input wire logic ext_clock_in,
    input wire logic ext_clock_lost,
    // Synthesizer and fixed free-run clocks
    input wire logic synth_clk,
    input wire logic t1_freerun_clk,
    input wire logic e1_freerun_clk,
    input wire logic line_e1_mode,
    // Synthesizer control
    output rcs_pkg::rcs_synth_ctl_t synth_ctl,
    // Reference output pin
    output logic ref_output_a,
    output logic ref_output_a_oe,
    // Status
    output logic ext_clock_rate_sel,
    output logic synth_bypass_active
);
    import rcs_pkg::*;

    // =====================================================================
    // Whole block state
    typedef struct packed {
        logic [7:0] src_cfg;
        logic [7:0] clk_cfg;
        logic wr_pend;
        logic [`RCS_ADDR_W-1:0] wr_addr;
        logic [31:0] hrdata;
        logic hready;
        rcs_out_mode_t mode;
        rcs_synth_ctl_t synth;
        logic pin;
        logic pin_oe;
        logic e1_sel;
        logic bypass;
        logic lost;
        logic code_bad;
    } rcs_top_state_t;

    rcs_top_state_t s_q;
    rcs_top_state_t s_d;
    rcs_src_t src;

    // =====================================================================
    // Source selection
    rcs_srcmux u_srcmux (
        .core_clk(core_clk),
        .srst(srst),
        .ref_source_code(s_q.src_cfg[`RCS_SRC_CODE_HI:`RCS_SRC_CODE_LO]),
        .recovered_channel_clock(recovered_channel_clock),
        .channel_clock_lost(channel_clock_lost),
        .ext_clock_in(ext_clock_in),
        .ext_clock_lost(ext_clock_lost),
        .src(src)
    );

    // =====================================================================
    // Next-state logic
    always_comb begin
        logic addr_ok;
        logic free_bit;
        logic byp_bit;
        logic hold_bit;
        logic [2:0] freq;
        logic [`RCS_ADDR_W-1:0] ra;
        addr_ok = 1'b0;
        free_bit = 1'b0;
        byp_bit = 1'b0;
        hold_bit = 1'b0;
        freq = 3'h0;
        ra = '0;
        s_d = s_q;

        // Data phase of a write lands here; no wait states are ever needed
        s_d.wr_pend = 1'b0;
        s_d.hready = 1'b1;
        if (s_q.wr_pend) begin
            unique case (s_q.wr_addr)
                `RCS_ADDR_SRC_CFG: begin
                    s_d.src_cfg = ahb_req.hwdata[7:0] & `RCS_SRC_WMASK;
                end
                `RCS_ADDR_CLK_CFG: begin
                    s_d.clk_cfg = ahb_req.hwdata[7:0] & `RCS_CLK_WMASK;
                end
                default: begin
                    // Unmapped or read-only: write dropped, still OKAY
                end
            endcase
        end

        // Address phase: reads see the value after any write just landing
        addr_ok = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
        ra = ahb_req.haddr[`RCS_ADDR_W-1:0];
        if (addr_ok && ahb_req.hwrite) begin
            s_d.wr_pend = 1'b1;
            s_d.wr_addr = ra;
        end
        if (addr_ok && !ahb_req.hwrite) begin
            unique case (ra)
                `RCS_ADDR_SRC_CFG: s_d.hrdata = {24'h000000, s_d.src_cfg};
                `RCS_ADDR_CLK_CFG: s_d.hrdata = {24'h000000, s_d.clk_cfg};
                `RCS_ADDR_STATUS: begin
                    s_d.hrdata = {24'h000000, 1'b0, s_q.code_bad, s_q.lost,
                                  src.is_ext, s_q.pin_oe, s_q.pin, s_q.mode};
                end
                default: s_d.hrdata = 32'h00000000;
            endcase
        end

        free_bit = s_q.clk_cfg[`RCS_CLK_FREE_BIT];
        byp_bit = s_q.clk_cfg[`RCS_CLK_BYP_BIT];
        hold_bit = s_q.clk_cfg[`RCS_CLK_HOLD_BIT];
        freq = s_q.clk_cfg[`RCS_CLK_FREQ_HI:`RCS_CLK_FREQ_LO];
        s_d.lost = src.lost;
        s_d.bypass = byp_bit;
        s_d.e1_sel = s_q.src_cfg[`RCS_SRC_E1_BIT];

        if (!src.lost) begin
            if (byp_bit) begin
                s_d.mode = RCS_OUT_SOURCE;
            end else begin
                s_d.mode = RCS_OUT_SYNTH;
            end
            s_d.synth.ref_master = !byp_bit && free_bit;
        end else if (src.is_ext) begin
            s_d.synth.ref_master = !byp_bit && free_bit;
            s_d.mode = (!byp_bit && free_bit) ? RCS_OUT_SYNTH : RCS_OUT_HIGH;
        end else if (!byp_bit) begin
            s_d.synth.ref_master = 1'b1;
            s_d.mode = (!free_bit && hold_bit) ? RCS_OUT_HIGH : RCS_OUT_SYNTH;
        end else begin
            s_d.synth.ref_master = 1'b0;
            s_d.mode = hold_bit ? RCS_OUT_HIGH : RCS_OUT_FIXED;
        end

        // code passed only while synthesizer in use
        if (!byp_bit) begin
            s_d.synth.freq_code = freq;
        end
        // undefined free-run code and reserved code flagged
        // remaining codes go straight to the synthesizer divider
        s_d.code_bad = !byp_bit && ((freq == `RCS_FREQ_RESERVED) ||
                       (s_d.synth.ref_master && freq == `RCS_FREQ_SRC_RATE));

        // Output pin level per mode
        unique case (s_d.mode)
            RCS_OUT_SYNTH: s_d.pin = synth_clk;
            RCS_OUT_SOURCE: s_d.pin = src.clk;
            RCS_OUT_FIXED: s_d.pin = line_e1_mode ? e1_freerun_clk : t1_freerun_clk;
            RCS_OUT_HIGH: s_d.pin = 1'b1;
        endcase
        s_d.pin_oe = s_q.src_cfg[`RCS_SRC_EN_BIT];
    end

    // =====================================================================
    // State register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.src_cfg <= `RCS_SRC_RESET;
            s_q.clk_cfg <= `RCS_CLK_RESET;
            s_q.hready <= 1'b1;
            s_q.mode <= RCS_OUT_SYNTH;
            s_q.pin <= 1'b1;
            s_q.pin_oe <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // =====================================================================
    // Outputs, all from flip-flops except hresp, which is tied to OKAY
    assign ahb_rsp.hreadyout = s_q.hready;
    assign ahb_rsp.hresp = 1'b0;
    assign ahb_rsp.hrdata = s_q.hrdata;
    assign synth_ctl = s_q.synth;
    assign ref_output_a = s_q.pin;
    assign ref_output_a_oe = s_q.pin_oe;
    assign ext_clock_rate_sel = s_q.e1_sel;
    assign synth_bypass_active = s_q.bypass;

endmodule // rcs_top

// ==== rcs_cfg.svh ====
// Offsets, field positions, reset values and codes for the reference clock select block
`ifndef RCS_CFG_SVH
`define RCS_CFG_SVH

// =====================================================================
// Register byte addresses
`define RCS_ADDR_SRC_CFG 12'h240
`define RCS_ADDR_CLK_CFG 12'h244
`define RCS_ADDR_STATUS 12'h248
`define RCS_ADDR_W 12

// =====================================================================
// Source configuration fields
`define RCS_SRC_EN_BIT 6
`define RCS_SRC_E1_BIT 5
`define RCS_SRC_CODE_HI 4
`define RCS_SRC_CODE_LO 0
`define RCS_SRC_WMASK 8'h7F
`define RCS_SRC_RESET 8'h41

// =====================================================================
// Clock configuration fields
`define RCS_CLK_HOLD_BIT 5
`define RCS_CLK_BYP_BIT 4
`define RCS_CLK_FREE_BIT 3
`define RCS_CLK_FREQ_HI 2
`define RCS_CLK_FREQ_LO 0
`define RCS_CLK_WMASK 8'h3F
`define RCS_CLK_RESET 8'h00

// =====================================================================
// Channel count and codes
`define RCS_NUM_CH 22
`define RCS_FIRST_EXT_CODE 5'h16
`define RCS_FREQ_SRC_RATE 3'h0
`define RCS_FREQ_RESERVED 3'h3

`endif

// ==== rcs_pkg.sv ====
// Types shared by the reference clock select block
package rcs_pkg;

    // =====================================================================
    // AHB-Lite request and response bundles
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } rcs_ahb_req_t;

    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } rcs_ahb_rsp_t;

    // =====================================================================
    // What drives the reference output pin
    typedef enum logic [1:0] {
        RCS_OUT_SYNTH = 2'b00,
        RCS_OUT_SOURCE = 2'b01,
        RCS_OUT_FIXED = 2'b10,
        RCS_OUT_HIGH = 2'b11
    } rcs_out_mode_t;

    // Control towards the frequency synthesizer
    typedef struct packed {
        logic ref_master;
        logic [2:0] freq_code;
    } rcs_synth_ctl_t;

    // Selected source as seen by the output stage
    typedef struct packed {
        logic clk;
        logic lost;
        logic is_ext;
    } rcs_src_t;

endpackage

// ==== rcs_srcmux.sv ====
// Source clock selector: one of the recovered channel clocks or the external clock
`timescale 1ns/1ps
`include "rcs_cfg.svh"

module rcs_srcmux (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Selection
    input wire logic [4:0] ref_source_code,
    // Candidate clocks and their loss flags
    input wire logic [`RCS_NUM_CH-1:0] recovered_channel_clock,
    input wire logic [`RCS_NUM_CH-1:0] channel_clock_lost,
    input wire logic ext_clock_in,
    input wire logic ext_clock_lost,
    // Selected source
    output rcs_pkg::rcs_src_t src
);
    import rcs_pkg::*;

    rcs_src_t state_q;
    rcs_src_t state_d;
    logic [`RCS_NUM_CH-1:0] hit;

    // =====================================================================
    // One-hot decode of the channel code
    genvar g;
    generate
        for (g = 0; g < `RCS_NUM_CH; g = g + 1) begin : g_ch
            assign hit[g] = (ref_source_code == 5'(g));
        end
    endgenerate

    // Pick clock and loss flag; codes past the last channel mean external
    always_comb begin
        state_d = '0;
        state_d.is_ext = (ref_source_code >= `RCS_FIRST_EXT_CODE);
        if (state_d.is_ext) begin
            state_d.clk = ext_clock_in;
            state_d.lost = ext_clock_lost;
        end else begin
            state_d.clk = |(hit & recovered_channel_clock);
            state_d.lost = |(hit & channel_clock_lost);
        end
    end

    // Registered so the output stage sees a clean level
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign src = state_q;

endmodule // rcs_srcmux

// ==== rcs_top_asserts.sv ====
// Concurrent checks on the reference clock select ports
`timescale 1ns/1ps
`include "rcs_cfg.svh"
module rcs_asserts (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Bus and loss inputs
    input rcs_pkg::rcs_ahb_req_t ahb_req,
    input wire logic [`RCS_NUM_CH-1:0] channel_clock_lost,
    input wire logic ext_clock_lost,
    // Outputs under check
    input rcs_pkg::rcs_synth_ctl_t synth_ctl,
    input wire logic ref_output_a,
    input wire logic ref_output_a_oe,
    input wire logic synth_bypass_active
);
    import rcs_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // =====================================================================
    // Shadow copies of both config registers
    logic tk, ext, lost, ws_q, wc_q;
    logic [7:0] src_q, clk_q;
    assign tk = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready && ahb_req.hwrite;
    assign ext = src_q[4:0] >= 5'd22;
    assign lost = ext ? ext_clock_lost : channel_clock_lost[src_q[4:0]];
    // Data phase flags, so the shadow takes hwdata at the same edge as the design
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ws_q <= 1'b0;
            wc_q <= 1'b0;
            src_q <= `RCS_SRC_RESET;
            clk_q <= `RCS_CLK_RESET;
        end else begin
            ws_q <= tk && ahb_req.haddr[11:0] == `RCS_ADDR_SRC_CFG;
            wc_q <= tk && ahb_req.haddr[11:0] == `RCS_ADDR_CLK_CFG;
            if (ws_q) src_q <= ahb_req.hwdata[7:0] & 8'h7F;
            if (wc_q) clk_q <= ahb_req.hwdata[7:0] & 8'h3F;
        end
    end
    // Loss held long enough to cover the two-cycle reaction
    sequence ext_hi_s;
        (ext && lost && (clk_q[4] || !clk_q[3]) && $stable(clk_q) && $stable(src_q))[*4];
    endsequence
    sequence hold_hi_s;
        (!ext && lost && clk_q[5] && (clk_q[4] || !clk_q[3]) && $stable(clk_q))[*4];
    endsequence
    chk_reset_vals: assert property (
        $fell(srst) |-> ref_output_a_oe && ref_output_a && synth_ctl == '0)
        else $error("reset values wrong");
    chk_oe_follow: assert property (
        ws_q |-> ##2 ref_output_a_oe == src_q[6]) else $error("pin enable lags");
    chk_byp_follow: assert property (
        wc_q |-> ##2 synth_bypass_active == clk_q[4]) else $error("bypass lags");
    chk_freq_pass: assert property (
        ($stable(clk_q) && !clk_q[4])[*3] |-> synth_ctl.freq_code == clk_q[2:0])
        else $error("freq code wrong");
    chk_free_master: assert property (
        ($stable(clk_q) && !clk_q[4] && clk_q[3])[*3] |-> synth_ctl.ref_master)
        else $error("free-run not on master");
    chk_locked_src: assert property (
        ($stable(clk_q) && $stable(src_q) && clk_q[4:3] == 2'h0 && !lost)[*4]
        |-> !synth_ctl.ref_master) else $error("not locked to source");
    chk_ext_high: assert property (
        ext_hi_s |-> ref_output_a) else $error("ext loss not high");
    chk_hold_high: assert property (
        hold_hi_s |-> ref_output_a) else $error("holdover not high");
endmodule // rcs_asserts

bind rcs_top rcs_asserts chk_u (
    .core_clk(core_clk),
    .srst(srst),
    .ahb_req(ahb_req),
    .channel_clock_lost(channel_clock_lost),
    .ext_clock_lost(ext_clock_lost),
    .synth_ctl(synth_ctl),
    .ref_output_a(ref_output_a),
    .ref_output_a_oe(ref_output_a_oe),
    .synth_bypass_active(synth_bypass_active)
);

// ==== rcs_top_test.sv ====
// Self-checking bench for the reference clock select block
`timescale 1ns/1ps
`include "rcs_cfg.svh"
module rcs_top_test;
    import rcs_pkg::*;
    // =====================================================================
    // Stimulus and observed signals
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [3:0] cnt = 4'h0;
    logic ext_lost = 1'b0;
    logic [21:0] ch_lost = 22'h0;
    rcs_ahb_req_t req;
    rcs_ahb_rsp_t rsp;
    rcs_synth_ctl_t sctl;
    logic pin, oe, rate, byp;
    int n_mismatch = 0;
    int total_checks = 0;
    // Loss cases: src, clk, ext lost, ch3 lost, expected mode
    logic [19:0] tbl [11] = '{20'h5600B, 20'h56088, 20'h5618B, 20'h43004, 20'h43207,
        20'h43284, 20'h43106, 20'h43307, 20'h431F1, 20'h55044, 20'h5F00B};
    always #5 core_clk = ~core_clk;
    // Toggling stand-ins for the candidate clocks
    always @(posedge core_clk) cnt <= cnt + 4'h1;
    assign req = '{hsel, haddr, htrans, hwrite, 3'h2, hwdata, rsp.hreadyout};
    rcs_top dut_u (
        .core_clk(core_clk),
        .srst(srst),
        .ahb_req(req),
        .ahb_rsp(rsp),
        .recovered_channel_clock({22{cnt[0]}}),
        .channel_clock_lost(ch_lost),
        .ext_clock_in(cnt[1]),
        .ext_clock_lost(ext_lost),
        .synth_clk(cnt[2]),
        .t1_freerun_clk(cnt[1]),
        .e1_freerun_clk(cnt[0]),
        .line_e1_mode(cnt[3]),
        .synth_ctl(sctl),
        .ref_output_a(pin),
        .ref_output_a_oe(oe),
        .ext_clock_rate_sel(rate),
        .synth_bypass_active(byp)
    );
    // One single transfer; waits on hready, no fixed latency assumed
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge core_clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 20'h0, a};
        do @(posedge core_clk); while (rsp.hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge core_clk); while (rsp.hreadyout !== 1'b1);
        r = rsp.hrdata;
    endtask
    // Status read after loss inputs have had time to land
    task automatic st(output logic [31:0] r);
        repeat (4) @(posedge core_clk);
        bus(1'b0, `RCS_ADDR_STATUS, 32'h0, r);
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Whole run is under 300 cycles; this cuts a hang at 10k
    initial begin
        #100us;
        n_mismatch++;
        final_report();
    end
    initial begin
        logic [31:0] v;
        logic [19:0] e;
        logic x;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        bus(1'b0, `RCS_ADDR_SRC_CFG, 32'h0, v);
        chk("src reset", v, 32'h41);
        bus(1'b0, `RCS_ADDR_CLK_CFG, 32'h0, v);
        chk("clk reset", v, 32'h0);
        chk("pin enable", oe, 32'h1);
        chk("rate sel", rate, 32'h0);
        bus(1'b1, `RCS_ADDR_SRC_CFG, 32'hFF, v);
        bus(1'b0, `RCS_ADDR_SRC_CFG, 32'h0, v);
        chk("src bit 7", v, 32'h7F);
        chk("rate sel", rate, 32'h1);
        bus(1'b1, `RCS_ADDR_SRC_CFG, 32'h01, v);
        bus(1'b0, 12'h2FC, 32'h0, v);
        chk("unmapped", v, 32'h0);
        chk("pin enable", oe, 32'h0);
        $display("test registers done");
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, `RCS_ADDR_CLK_CFG, c, v);
            st(v);
            chk("freq code", sctl.freq_code, c[2:0]);
            chk("bad code", v[6], c == 3);
            chk("locked", sctl.ref_master, 32'h0);
        end
        bus(1'b1, `RCS_ADDR_CLK_CFG, 32'h08, v);
        st(v);
        chk("free master", sctl.ref_master, 32'h1);
        chk("bad code", v[6], 32'h1);
        bus(1'b1, `RCS_ADDR_CLK_CFG, 32'h1D, v);
        st(v);
        chk("bypass mode", v[1:0], 32'h1);
        chk("freq held", sctl.freq_code, 32'h0);
        chk("bypass out", byp, 32'h1);
        chk("okay resp", rsp.hresp, 32'h0);
        $display("test synthesizer done");
        for (int i = 0; i < 11; i++) begin
            e = tbl[i];
            bus(1'b1, `RCS_ADDR_SRC_CFG, e[19:12], v);
            bus(1'b1, `RCS_ADDR_CLK_CFG, e[11:4], v);
            ext_lost <= e[3];
            ch_lost <= e[2] ? 22'h8 : 22'h0;
            st(v);
            x = (e[16:12] >= 5'd22) ? e[3] : (e[2] && e[16:12] == 5'd3);
            chk("loss mode", {v[5:3], v[1:0]}, {x, e[16:12] >= 5'd22, 1'b1, e[1:0]});
            if (e[1:0] == 2'h3) chk("pin high", pin, 32'h1);
        end
        $display("test loss table done");
        final_report();
    end
endmodule // rcs_top_test
